/* File: logic/mat_top.v */
`timescale 1ns/1ps
`include "mat_defs.vh"
// Function
// (RQ1) Separate instruction and data buffers, concurrent
// (RQ2) Instruction buffer 64 entries, two ways
// (RQ3) Data buffer 64 entries, two ways
// (RQ4) Four KB pages, 256 MB segments
// (RQ5) Segment forms 52-bit virtual address
// (RQ6) Block sizes 128 KB to 256 MB
// (RQ7) Segment descriptors held in on-chip registers
// (RQ8) Block entries are supervisor-only register pairs
// (RQ9) Little-endian variant adds four block entries
// (RQ10) Three miss kinds set saved state bits
// (RQ11) Missed address captured per side
// (RQ12) Hash, compare and staged entry registers
// (RQ13) Two load commands write buffer entries
// (RQ14) Handler maps registers 0-3 to shadows
// (RQ15) Invalidate command removes cached translations
// (RQ16) Referenced and changed bits maintained
// (RQ17) Table mask limits hash address
// (RQ18) No-execute, user/supervisor, read-only enforced
// (RQ19) Top four address bits pick segment
// (RQ20) Low twelve address bits pass through
// (RQ21) Block match overrides page translation
// (RQ22) Translation disabled gives physical equals effective
// (RQ23) Victim way chosen by per-set LRU

// ****************************************************
// One translation side: buffer, block entries, lookup
// ****************************************************
module mat_side #(
  parameter IS_INSTR = 1,
  parameter NB       = 4
) (
  // Clock and reset
  input  wire           pclk,
  input  wire           presetn,
  // Lookup request
  input  wire           req,
  input  wire [31:0]    ea,
  input  wire           user,
  input  wire           store,
  input  wire           xlate_en,
  input  wire [31:0]    seg,
  // Configuration
  input  wire [31:0]    pt_base,
  input  wire [NB*32-1:0] blk_up,
  input  wire [NB*32-1:0] blk_lo,
  // Entry maintenance
  input  wire           ld,
  input  wire           inv,
  input  wire [31:0]    op_ea,
  input  wire [31:0]    stg_cmp,
  input  wire [31:0]    stg_ent,
  // Results
  output reg            done,
  output reg  [31:0]    pa,
  output reg            miss,
  output reg            fault,
  output reg  [31:0]    miss_ea,
  output reg  [31:0]    miss_cmp,
  output reg  [31:0]    miss_h1,
  output reg  [31:0]    miss_h2,
  output reg            miss_key,
  output reg            miss_way,
  output reg            hit_ref
);
  reg        tv   [0:63];
  reg [34:0] ttag [0:63];
  reg [19:0] trpn [0:63];
  reg [1:0]  tpp  [0:63];
  reg        tc   [0:63];
  reg        tr   [0:63];
  reg [31:0] lru;
  reg        bhit;
  reg [31:0] bpa;
  reg        bok;
  integer    k;
  integer    j;

  // Access allowed for a key and protection pair
  function pp_ok;
    input       key;
    input [1:0] pp;
    input       wr;
    begin
      pp_ok = key ? (pp == 2'b10 || (!wr && pp != 2'b00))
                  : (!wr || pp != 2'b11);
    end
  endfunction

  // Group address from base, mask and hash
  function [31:0] grp;
    input [31:0] base;
    input [18:0] h;
    begin
      grp = {base[31:25], base[24:16] | (h[18:10] & base[8:0]),
             h[9:0], 6'h00}; // RQ17
    end
  endfunction

  wire [4:0]  set  = ea[16:12];
  wire [5:0]  i0   = {1'b0, set};
  wire [5:0]  i1   = {1'b1, set};
  // Virtual tag: segment id and page index above set bits
  wire [34:0] tag  = {seg[23:0], ea[27:17]}; // RQ5
  wire        h0   = tv[i0] && ttag[i0] == tag;
  wire        h1   = tv[i1] && ttag[i1] == tag;
  wire [5:0]  hi   = h1 ? i1 : i0;
  wire        key  = user ? seg[`MAT_SEG_KP] : seg[`MAT_SEG_KS];
  wire [18:0] hash = seg[18:0] ^ {3'h0, ea[27:12]};
  wire [5:0]  li   = {lru[op_ea[16:12]], op_ea[16:12]};

  // Block entries in parallel, lowest index wins
  always @*
  begin
    bhit = 1'b0;
    bpa  = 32'h00000000;
    bok  = 1'b0;
    for (k = NB - 1; k >= 0; k = k - 1)
    begin
      if (((ea[31:17] & ~{4'h0, blk_up[k*32+2 +: 11]}) ==
           blk_up[k*32+17 +: 15]) &&
          (user ? blk_up[k*32+`MAT_BLK_VP]
                : blk_up[k*32+`MAT_BLK_VS])) // RQ6
      begin
        bhit = 1'b1;
        bpa  = {blk_lo[k*32+17 +: 15] |
                (ea[31:17] & {4'h0, blk_up[k*32+2 +: 11]}),
                ea[16:0]};
        bok  = pp_ok(1'b1, blk_lo[k*32 +: 2], store); // RQ18
      end
    end
  end

  // Lookup, entry load, invalidate and LRU upkeep
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (j = 0; j < 64; j = j + 1)
      begin
        tv[j]   <= 1'b0;
        ttag[j] <= 35'h000000000;
        trpn[j] <= 20'h00000;
        tpp[j]  <= 2'h0;
        tc[j]   <= 1'b0;
        tr[j]   <= 1'b0;
      end
      lru      <= 32'h00000000;
      done     <= 1'b0;
      pa       <= 32'h00000000;
      miss     <= 1'b0;
      fault    <= 1'b0;
      miss_ea  <= 32'h00000000;
      miss_cmp <= 32'h00000000;
      miss_h1  <= 32'h00000000;
      miss_h2  <= 32'h00000000;
      miss_key <= 1'b0;
      miss_way <= 1'b0;
      hit_ref  <= 1'b0;
    end
    else
    begin
      done  <= req;
      miss  <= 1'b0;
      fault <= 1'b0;
      if (req)
      begin
        if (!xlate_en)
          pa <= ea; // RQ22
        else if (bhit)
        begin
          // A refused block access leaves the last address in place
          if (bok)
            pa <= bpa; // RQ21
          fault <= !bok;
        end
        else if (seg[`MAT_SEG_T] ||
                 (IS_INSTR != 0 && seg[`MAT_SEG_NX]))
          fault <= 1'b1; // RQ18
        else if (h0 || h1)
        begin
          hit_ref  <= tr[hi];
          tr[hi]   <= 1'b1; // RQ16
          lru[set] <= ~h1; // RQ23
          if (!pp_ok(key, tpp[hi], store))
            fault <= 1'b1; // RQ18
          else if (store && !tc[hi])
            miss <= 1'b1; // RQ10
          else
            pa <= {trpn[hi], ea[11:0]}; // RQ20
        end
        else
          miss <= 1'b1; // RQ10
        if (xlate_en && !bhit && !seg[`MAT_SEG_T] &&
            !(IS_INSTR != 0 && seg[`MAT_SEG_NX]) &&
            (!(h0 || h1) || (store && !tc[hi] &&
             pp_ok(key, tpp[hi], store))))
        begin
          miss_ea  <= ea; // RQ11
          miss_cmp <= {1'b1, seg[23:0], 1'b0, ea[27:22]}; // RQ12
          miss_h1  <= grp(pt_base, hash);
          miss_h2  <= grp(pt_base, ~hash);
          miss_key <= key;
          miss_way <= lru[set];
        end
      end
      if (ld)
      begin
        tv[li]   <= 1'b1; // RQ13
        ttag[li] <= {stg_cmp[30:7], op_ea[27:17]};
        trpn[li] <= stg_ent[31:12];
        tpp[li]  <= stg_ent[1:0];
        tc[li]   <= stg_ent[`MAT_STG_C];
        tr[li]   <= stg_ent[`MAT_STG_R];
        lru[op_ea[16:12]] <= ~lru[op_ea[16:12]]; // RQ23
      end
      if (inv)
      begin
        tv[{1'b0, op_ea[16:12]}] <= 1'b0; // RQ15
        tv[{1'b1, op_ea[16:12]}] <= 1'b0;
      end
    end
  end
endmodule

// ****************************************************
// Top: APB registers and both sides
// ****************************************************
module mat_top #(
  parameter LE_VARIANT = 0
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  input  wire [2:0]  pprot,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Instruction fetch side
  input  wire        i_req,
  input  wire [31:0] i_ea,
  output wire        i_done,
  output wire [31:0] i_pa,
  output wire        i_miss,
  output wire        i_fault,
  // Load/store side
  input  wire        d_req,
  input  wire [31:0] d_ea,
  input  wire        d_store,
  output wire        d_done,
  output wire [31:0] d_pa,
  output wire        d_miss,
  output wire        d_fault,
  // Handler register shadowing
  output wire        shadow_map
);
  localparam NB = 4 + 4 * LE_VARIANT; // RQ9

  reg  [31:0]    mstate, saved, ptbase, staged, status;
  reg  [31:0]    seg    [0:15];
  reg  [31:0]    shadow [0:3];
  reg  [NB*32-1:0] ibu, ibl, dbu, dbl;
  reg            last_d, ld_i, ld_d, inv, d_store_q;
  reg  [31:0]    op_ea;
  reg  [31:0]    next_rdata;
  reg            next_err;
  wire [31:0]    instruction_miss_address, data_miss_address, instruction_entry_compare, data_entry_compare, ih1, ih2, dh1, dh2;
  wire           ikey, iway, dkey, dway, iref, dref;
  integer        k;

  // Byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  wire       priv  = pprot[0];
  wire [2:0] bidx  = paddr[5:3];
  wire       is_bk = (paddr[11:6] == `MAT_PAGE_IBLK ||
                      paddr[11:6] == `MAT_PAGE_DBLK);
  wire       bk_ok = ({29'h0, bidx} < NB) && priv; // RQ8
  wire       wr_go = psel && penable && pready && pwrite && !pslverr;
  assign shadow_map = mstate[`MAT_MS_SHAD];

  // Read data and error decode in the setup cycle
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (paddr[11:6] == `MAT_PAGE_SEG)
      next_rdata = seg[paddr[5:2]]; // RQ7
    else if (paddr[11:4] == `MAT_PAGE_SHADOW)
      next_rdata = shadow[paddr[3:2]]; // RQ14
    else if (is_bk)
    begin
      next_err = !bk_ok;
      if (bk_ok && paddr[11:6] == `MAT_PAGE_IBLK)
        next_rdata = paddr[2] ? ibl[bidx*32 +: 32] : ibu[bidx*32 +: 32];
      else if (bk_ok)
        next_rdata = paddr[2] ? dbl[bidx*32 +: 32] : dbu[bidx*32 +: 32];
    end
    else
      case (paddr)
        `MAT_OFF_MSTATE: next_rdata = mstate;
        `MAT_OFF_SAVED:  next_rdata = saved;
        `MAT_OFF_PTBASE: next_rdata = ptbase;
        `MAT_OFF_STAGED: next_rdata = staged;
        `MAT_OFF_INSTRUCTION_MISS_ADDRESS:  next_rdata = instruction_miss_address; // RQ11
        `MAT_OFF_DATA_MISS_ADDRESS:  next_rdata = data_miss_address;
        `MAT_OFF_INSTRUCTION_ENTRY_COMPARE:   next_rdata = instruction_entry_compare; // RQ12
        `MAT_OFF_DATA_ENTRY_COMPARE:   next_rdata = data_entry_compare;
        `MAT_OFF_PRIMARY_GROUP_ADDRESS:  next_rdata = last_d ? dh1 : ih1;
        `MAT_OFF_SECONDARY_GROUP_ADDRESS:  next_rdata = last_d ? dh2 : ih2;
        `MAT_OFF_LOAD_I: next_rdata = 32'h00000000;
        `MAT_OFF_LOAD_D: next_rdata = 32'h00000000;
        `MAT_OFF_INVAL:  next_rdata = 32'h00000000;
        `MAT_OFF_STATUS: next_rdata = status;
        default:         next_err   = 1'b1;
      endcase
  end

  // APB handshake, register writes and miss capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      mstate  <= `MAT_RST_MSTATE;
      saved   <= `MAT_RST_WORD;
      ptbase  <= `MAT_RST_PTBASE;
      staged  <= `MAT_RST_WORD;
      status  <= `MAT_RST_WORD;
      for (k = 0; k < 16; k = k + 1)
        seg[k] <= `MAT_RST_WORD;
      for (k = 0; k < 4; k = k + 1)
        shadow[k] <= `MAT_RST_WORD;
      ibu    <= {NB{`MAT_RST_WORD}};
      ibl    <= {NB{`MAT_RST_WORD}};
      dbu    <= {NB{`MAT_RST_WORD}};
      dbl    <= {NB{`MAT_RST_WORD}};
      last_d <= 1'b0;
      ld_i   <= 1'b0;
      ld_d   <= 1'b0;
      inv    <= 1'b0;
      op_ea  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      ld_i    <= 1'b0;
      ld_d    <= 1'b0;
      inv     <= 1'b0;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end
      status <= {30'h0, dref, iref}; // RQ16
      if (wr_go)
      begin
        if (paddr[11:6] == `MAT_PAGE_SEG)
          seg[paddr[5:2]] <= merge(seg[paddr[5:2]], pwdata, pstrb);
        else if (paddr[11:4] == `MAT_PAGE_SHADOW)
          shadow[paddr[3:2]] <= merge(shadow[paddr[3:2]], pwdata, pstrb);
        else if (paddr[11:6] == `MAT_PAGE_IBLK && paddr[2])
          ibl[bidx*32 +: 32] <= merge(ibl[bidx*32 +: 32], pwdata, pstrb);
        else if (paddr[11:6] == `MAT_PAGE_IBLK)
          ibu[bidx*32 +: 32] <= merge(ibu[bidx*32 +: 32], pwdata, pstrb);
        else if (paddr[11:6] == `MAT_PAGE_DBLK && paddr[2])
          dbl[bidx*32 +: 32] <= merge(dbl[bidx*32 +: 32], pwdata, pstrb);
        else if (paddr[11:6] == `MAT_PAGE_DBLK)
          dbu[bidx*32 +: 32] <= merge(dbu[bidx*32 +: 32], pwdata, pstrb);
        else
          case (paddr)
            `MAT_OFF_MSTATE: mstate <= merge(mstate, pwdata, pstrb);
            `MAT_OFF_SAVED:  saved  <= merge(saved, pwdata, pstrb);
            `MAT_OFF_PTBASE: ptbase <= merge(ptbase, pwdata, pstrb);
            `MAT_OFF_STAGED: staged <= merge(staged, pwdata, pstrb);
            `MAT_OFF_LOAD_I: ld_i   <= 1'b1; // RQ13
            `MAT_OFF_LOAD_D: ld_d   <= 1'b1;
            `MAT_OFF_INVAL:  inv    <= 1'b1; // RQ15
            default:         op_ea  <= op_ea;
          endcase
        op_ea <= pwdata;
      end
      // Miss entry: set wins over a same-cycle software write
      if (i_miss || d_miss)
      begin
        mstate[`MAT_MS_SHAD] <= 1'b1; // RQ14
        last_d <= d_miss;
        saved[`MAT_SS_DSIDE] <= d_miss; // RQ10
        saved[`MAT_SS_STORE] <= d_miss && d_store_q;
        saved[`MAT_SS_KEY]   <= d_miss ? dkey : ikey;
        saved[`MAT_SS_WAY]   <= d_miss ? dway : iway;
      end
    end
  end

  // Store flag of the lookup in flight
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      d_store_q <= 1'b0;
    else
      d_store_q <= d_store;
  end

  // Instruction side, segment chosen by top four bits
  mat_side #(.IS_INSTR(1), .NB(NB)) u_iside (
    .pclk(pclk), .presetn(presetn), .req(i_req), .ea(i_ea),
    .user(mstate[`MAT_MS_USER]), .store(1'b0),
    .xlate_en(mstate[`MAT_MS_IEN]), .seg(seg[i_ea[31:28]]), // RQ19
    .pt_base(ptbase), .blk_up(ibu), .blk_lo(ibl),
    .ld(ld_i), .inv(inv), .op_ea(op_ea), .stg_cmp(instruction_entry_compare),
    .stg_ent(staged), .done(i_done), .pa(i_pa), .miss(i_miss),
    .fault(i_fault), .miss_ea(instruction_miss_address), .miss_cmp(instruction_entry_compare),
    .miss_h1(ih1), .miss_h2(ih2), .miss_key(ikey),
    .miss_way(iway), .hit_ref(iref)); // RQ1 RQ2

  // Data side, own buffer and block entries, invalidate shared with fetch side
  mat_side #(.IS_INSTR(0), .NB(NB)) u_dside (
    .pclk(pclk), .presetn(presetn), .req(d_req), .ea(d_ea),
    .user(mstate[`MAT_MS_USER]), .store(d_store),
    .xlate_en(mstate[`MAT_MS_DEN]), .seg(seg[d_ea[31:28]]), // RQ19
    .pt_base(ptbase), .blk_up(dbu), .blk_lo(dbl),
    .ld(ld_d), .inv(inv), .op_ea(op_ea), .stg_cmp(data_entry_compare),
    .stg_ent(staged), .done(d_done), .pa(d_pa), .miss(d_miss),
    .fault(d_fault), .miss_ea(data_miss_address), .miss_cmp(data_entry_compare),
    .miss_h1(dh1), .miss_h2(dh2), .miss_key(dkey),
    .miss_way(dway), .hit_ref(dref)); // RQ3 RQ4
endmodule

/* File: include/mat_defs.vh */
`ifndef MAT_DEFS_VH
`define MAT_DEFS_VH
// ****************************************************
// Register byte offsets
// ****************************************************
`define MAT_OFF_MSTATE   12'h000
`define MAT_OFF_SAVED    12'h004
`define MAT_OFF_PTBASE   12'h008
`define MAT_OFF_STAGED   12'h00C
`define MAT_OFF_INSTRUCTION_MISS_ADDRESS    12'h010
`define MAT_OFF_DATA_MISS_ADDRESS    12'h014
`define MAT_OFF_INSTRUCTION_ENTRY_COMPARE     12'h018
`define MAT_OFF_DATA_ENTRY_COMPARE     12'h01C
`define MAT_OFF_PRIMARY_GROUP_ADDRESS    12'h020
`define MAT_OFF_SECONDARY_GROUP_ADDRESS    12'h024
`define MAT_OFF_LOAD_I   12'h028
`define MAT_OFF_LOAD_D   12'h02C
`define MAT_OFF_INVAL    12'h030
`define MAT_OFF_STATUS   12'h034
`define MAT_PAGE_SEG     6'h01
`define MAT_PAGE_IBLK    6'h02
`define MAT_PAGE_DBLK    6'h03
`define MAT_PAGE_SHADOW  8'h10
// ****************************************************
// Field positions
// ****************************************************
`define MAT_MS_IEN   0
`define MAT_MS_DEN   1
`define MAT_MS_USER  2
`define MAT_MS_SHAD  3
`define MAT_SS_STORE 16
`define MAT_SS_WAY   17
`define MAT_SS_KEY   18
`define MAT_SS_DSIDE 19
`define MAT_SEG_T    31
`define MAT_SEG_KS   30
`define MAT_SEG_KP   29
`define MAT_SEG_NX   28
`define MAT_BLK_VS   1
`define MAT_BLK_VP   0
`define MAT_STG_R    8
`define MAT_STG_C    7
// ****************************************************
// Reset values
// ****************************************************
`define MAT_RST_MSTATE 32'h00000000
`define MAT_RST_PTBASE 32'h00000000
`define MAT_RST_WORD   32'h00000000
`endif

/* File: tb/mat_chk_assertions.sv */
`timescale 1ns/1ps
// ****************************************************
// Lookup and register bus timing checks
// ****************************************************
module mat_chk (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // Fetch side
  input wire        i_req,
  input wire [31:0] i_ea,
  input wire        i_done,
  input wire [31:0] i_pa,
  input wire        i_miss,
  input wire        i_fault,
  // Data side
  input wire        d_req,
  input wire [31:0] d_ea,
  input wire        d_done,
  input wire [31:0] d_pa,
  input wire        d_miss,
  input wire        d_fault
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Requests that come back translated
  sequence s_i_good;
    i_req ##1 (i_done && !i_miss && !i_fault);
  endsequence
  sequence s_d_good;
    d_req ##1 (d_done && !d_miss && !d_fault);
  endsequence

  property p_i_ans;
    i_req |=> i_done && !(i_miss && i_fault);
  endproperty
  a_i_ans: assert property (p_i_ans)
    else $error("fetch answer missing");
  property p_d_ans;
    d_req |=> d_done && !(d_miss && d_fault);
  endproperty
  a_d_ans: assert property (p_d_ans)
    else $error("data answer missing");
  property p_i_quiet;
    !i_req |=> !i_done && !i_miss && !i_fault;
  endproperty
  a_i_quiet: assert property (p_i_quiet)
    else $error("fetch answer without request");
  property p_i_low;
    s_i_good |-> i_pa[11:0] == $past(i_ea[11:0]);
  endproperty
  a_i_low: assert property (p_i_low)
    else $error("fetch page offset changed");
  property p_d_low;
    s_d_good |-> d_pa[11:0] == $past(d_ea[11:0]);
  endproperty
  a_d_low: assert property (p_d_low)
    else $error("data page offset changed");
  property p_i_hold;
    i_done && (i_miss || i_fault) |-> $stable(i_pa);
  endproperty
  a_i_hold: assert property (p_i_hold)
    else $error("fetch address moved on miss");
  property p_d_hold;
    d_done && (d_miss || d_fault) |-> $stable(d_pa);
  endproperty
  a_d_hold: assert property (p_d_hold)
    else $error("data address moved on miss");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err)
    else $error("error outside access cycle");
  property p_apb;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("bus answer not one cycle");
endmodule

bind mat_top mat_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .i_req(i_req), .i_ea(i_ea),
  .i_done(i_done), .i_pa(i_pa), .i_miss(i_miss), .i_fault(i_fault),
  .d_req(d_req), .d_ea(d_ea), .d_done(d_done), .d_pa(d_pa),
  .d_miss(d_miss), .d_fault(d_fault)
);

/* File: tb/mat_req_model.sv */
`timescale 1ns/1ps
// ****************************************************
// Fetch or load/store unit issuing lookups
// ****************************************************
module mat_req_model (
  // Clock
  input  wire        pclk,
  // Lookup request
  output reg         req,
  output reg  [31:0] ea,
  output reg         store
);
  // Quiet start
  initial
  begin
    req = 1'b0;
    ea = 32'h00000000;
    store = 1'b0;
  end
  // One pulse; idle lines then show the inverse, never stale data
  task issue(input [31:0] a, input s);
    begin
      @(posedge pclk);
      req <= 1'b1;
      ea <= a;
      store <= s;
      @(posedge pclk);
      req <= 1'b0;
      ea <= ~a;
      store <= ~s;
    end
  endtask
endmodule

/* File: tb/mmu_address_translation_test.sv */
`timescale 1ns/1ps
`include "mat_defs.vh"
// ****************************************************
// Translation unit bench
// ****************************************************
module mmu_address_translation_test;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  reg  [2:0]  pprot;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        i_req;
  wire [31:0] i_ea;
  wire        i_done;
  wire [31:0] i_pa;
  wire        i_miss;
  wire        i_fault;
  wire        d_req;
  wire [31:0] d_ea;
  wire        d_store;
  wire        d_done;
  wire [31:0] d_pa;
  wire        d_miss;
  wire        d_fault;
  wire        shadow_map;
  integer     error_cnt;
  integer     checks_done;
  integer     seed;
  integer     cyc;
  reg  [31:0] a;
  reg  [31:0] b;
  reg  [31:0] rdv;
  reg         erv;

  mat_top #(.LE_VARIANT(0)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_req(i_req), .i_ea(i_ea), .i_done(i_done), .i_pa(i_pa),
    .i_miss(i_miss), .i_fault(i_fault), .d_req(d_req), .d_ea(d_ea),
    .d_store(d_store), .d_done(d_done), .d_pa(d_pa), .d_miss(d_miss),
    .d_fault(d_fault), .shadow_map(shadow_map));
  mat_req_model u_imod (.pclk(pclk), .req(i_req), .ea(i_ea), .store());
  mat_req_model u_dmod (.pclk(pclk), .req(d_req), .ea(d_ea),
    .store(d_store));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  // Expected address and entry builders
  function [31:0] pg(input [19:0] rpn, input [31:0] e);
    pg = {rpn, e[11:0]};
  endfunction
  function [31:0] stg(input [19:0] rpn, input c, input [1:0] pp);
    stg = {rpn, 4'h0, c, 5'h00, pp};
  endfunction

  task automatic cmp(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // One APB transfer, waiting for pready; the hang guard ends a stall
  task apb(input w, input [11:0] ad, input [31:0] d, input pr);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pprot <= {2'b00, pr};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        n = n + 1;
        @(posedge pclk);
      end
      cmp(n, 0);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    apb(1'b1, ad, d, 1'b1);
  endtask
  // One lookup and its answer one cycle later
  task automatic xlat(input d, input [31:0] e, input s, input m,
    input f, input [31:0] pa);
    begin
      if (d)
        u_dmod.issue(e, s);
      else
        u_imod.issue(e, 1'b0);
      #1;
      cmp(d ? d_done : i_done, 1);
      cmp(d ? d_miss : i_miss, m);
      cmp(d ? d_fault : i_fault, f);
      if (!m && !f)
        cmp(d ? d_pa : i_pa, pa);
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pprot} = 0;
    pstrb = 4'hF;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    seed = 6;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MAT_OFF_MSTATE, 0, 1'b1);
    cmp(rdv, `MAT_RST_MSTATE);
    repeat (8)
    begin
      a = $random(seed);
      b = $random(seed);
      fork
        xlat(1'b0, a, 1'b0, 1'b0, 1'b0, a);
        xlat(1'b1, b, b[0], 1'b0, 1'b0, b);
      join
    end
    wr(12'h054, 32'h00000ABC);
    wr(12'h058, 32'h80000000);
    wr(`MAT_OFF_MSTATE, 32'h00000003);
    a = 32'h51234000 | ($random(seed) & 32'hFFF);
    xlat(1'b0, a, 1'b0, 1'b1, 1'b0, 0);
    @(posedge pclk);
    #1;
    cmp(shadow_map, 1);
    apb(1'b0, `MAT_OFF_INSTRUCTION_MISS_ADDRESS, 0, 1'b1);
    cmp(rdv, a);
    wr(`MAT_OFF_STAGED, stg(20'hABCDE, 1'b1, 2'b00));
    wr(`MAT_OFF_LOAD_I, a);
    a[11:0] = $random(seed);
    xlat(1'b0, a, 1'b0, 1'b0, 1'b0, pg(20'hABCDE, a));
    xlat(1'b0, 32'h60000000, 1'b0, 1'b0, 1'b1, 0);
    b = 32'h54445000 | ($random(seed) & 32'hFFF);
    xlat(1'b1, b, 1'b0, 1'b1, 1'b0, 0);
    apb(1'b0, `MAT_OFF_DATA_MISS_ADDRESS, 0, 1'b1);
    cmp(rdv, b);
    wr(`MAT_OFF_STAGED, stg(20'h12345, 1'b0, 2'b10));
    wr(`MAT_OFF_LOAD_D, b);
    xlat(1'b1, b, 1'b0, 1'b0, 1'b0, pg(20'h12345, b));
    xlat(1'b1, b, 1'b1, 1'b1, 1'b0, 0);
    apb(1'b0, `MAT_OFF_SAVED, 0, 1'b1);
    cmp(rdv, 32'h000B0000);
    wr(`MAT_OFF_INVAL, b);
    wr(`MAT_OFF_STAGED, stg(20'h12345, 1'b1, 2'b11));
    wr(`MAT_OFF_LOAD_D, b);
    xlat(1'b1, b, 1'b1, 1'b0, 1'b1, 0);
    wr(`MAT_OFF_INVAL, a);
    xlat(1'b0, a, 1'b0, 1'b1, 1'b0, 0);
    apb(1'b1, 12'h080, {a[31:17], 17'h00002}, 1'b0);
    cmp(erv, 1);
    apb(1'b1, 12'h0A0, 32'h00000002, 1'b1);
    cmp(erv, 1);
    wr(12'h080, {a[31:17], 17'h00002});
    wr(12'h084, {15'h0F0F, 15'h0000, 2'b10});
    xlat(1'b0, a, 1'b0, 1'b0, 1'b0, {15'h0F0F, a[16:0]});
    apb(1'b0, 12'h3FC, 0, 1'b1);
    cmp(erv, 1);
    cmp(rdv, 32'h00000000);
    wrap_up;
  end
endmodule
